// >>> logic/ttc_duty_mod.sv
// Core clock gate modulator with a duty of one to seven eighths clocks-on.
// Assumes the duty is steady while run is high; a change applies from the next clock cycle.
module ttc_duty_mod
(
  input  wire logic       mclk,  // Core clock.
  input  wire logic       nrst,  // Synchronous reset, active low.
  input  wire logic       run,   // Modulate while high.
  input  wire logic [2:0] duty,  // Clocks-on eighths, 1 to 7.
  output logic            clkOn  // Core clocks allowed to run.
);

  typedef struct packed {
    logic [7:0] slotCnt;
    logic [2:0] slot;
    logic       on;
  } ttc_mod_t;

  ttc_mod_t s_q;
  ttc_mod_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (!run)
    begin
      s_d.slotCnt = '0;
      s_d.slot = '0;
      s_d.on = 1'b1;
    end
    else
    begin
      // The period is a fixed count of core cycles, so it shortens as the clock speeds up.
      if (s_q.slotCnt == ttc_pkg::SLOT_LAST)
      begin
        s_d.slotCnt = '0;
        s_d.slot = s_q.slot + 3'h1;
      end
      else
      begin
        s_d.slotCnt = s_q.slotCnt + 8'h01;
      end
      s_d.on = (s_d.slot < duty);
    end
    if (!nrst)
    begin
      s_d = '0;
      s_d.on = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign clkOn = s_q.on;

endmodule

// >>> logic/ttc_pkg.sv
// Constants, register map and mode encoding for the thermal throttle control block.
// Assumes a single 25 MHz core clock and an APB register port with 32-bit data.
package ttc_pkg;

  // Core clock rate in MHz.
  localparam int CLK_MHZ = 25;

  // Time that the performance-state response is given before clock modulation joins it.
  localparam int PERF_SETTLE_US = 100;
  localparam int PERF_SETTLE_CYC = PERF_SETTLE_US * CLK_MHZ;
  localparam logic [11:0] SETTLE_LAST = 12'(PERF_SETTLE_CYC - 1);

  // Last cycle count of one eighth of a modulation period; each eighth lasts 16 clock cycles, the period 128.
  localparam logic [7:0] SLOT_LAST = 8'h0f;

  // Factory duty of the fixed automatic mode, in eighths clocks-on.
  localparam logic [2:0] FIXED_DUTY = 3'h4;
  localparam logic [2:0] DUTY_RESERVED = 3'h0;

  // Width of the synchronised pin group.
  localparam int SYNC_W = 4;

  // Register byte addresses.
  localparam logic [11:0] ADDR_ONDEMAND = 12'h000;
  localparam logic [11:0] ADDR_AUTO = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_COUNT = 12'h00c;
  localparam logic [11:0] ADDR_DIODE = 12'h010;

  // On-demand control fields.
  localparam int OD_EN_BIT = 4;
  localparam int OD_DUTY_LSB = 1;
  localparam int OD_DUTY_MSB = 3;

  // Automatic mode configuration fields.
  localparam int AUTO_FIXED_BIT = 0;
  localparam int AUTO_PERF_BIT = 1;
  localparam int AUTO_FORCE_BIT = 2;
  localparam int IRQ_RISE_BIT = 4;
  localparam int IRQ_FALL_BIT = 5;
  localparam int PSTATE_LSB = 8;
  localparam int PSTATE_MSB = 11;

  // Status fields.
  localparam int ST_THROTTLE = 0;
  localparam int ST_HOT = 1;
  localparam int ST_OVERHEAT = 2;
  localparam int ST_HOTLOG = 3;
  localparam int ST_PSTATE = 4;
  localparam int ST_MOD = 5;

  // Diode correction fields; ideality is held in hundredths.
  localparam int DIODE_OFS_LSB = 0;
  localparam int IDEAL_LSB = 16;
  localparam logic [7:0] IDEALITY_HUNDREDTHS = 8'h65;

  typedef enum logic [1:0] {
    AUTO_RUN      = 2'b00,
    AUTO_PERF     = 2'b01,
    AUTO_COMBINED = 2'b10,
    AUTO_FIXED    = 2'b11
  } ttc_auto_t;

endpackage

// >>> logic/ttc_sync3.sv
// Three-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are slow levels; each bit moves once stages two and three agree.
module ttc_sync3
(
  input  wire logic                      mclk, // Core clock.
  input  wire logic                      nrst, // Synchronous reset, active low.
  input  wire logic [ttc_pkg::SYNC_W-1:0] din,  // Asynchronous levels.
  output logic      [ttc_pkg::SYNC_W-1:0] dout  // Filtered levels.
);

  typedef struct packed {
    logic [ttc_pkg::SYNC_W-1:0] s1;
    logic [ttc_pkg::SYNC_W-1:0] s2;
    logic [ttc_pkg::SYNC_W-1:0] s3;
    logic [ttc_pkg::SYNC_W-1:0] out;
  } ttc_sync_t;

  ttc_sync_t s_q;
  ttc_sync_t s_d;
  logic [ttc_pkg::SYNC_W-1:0] agree;

  always_comb
  begin
    agree = ~(s_q.s2 ^ s_q.s3);
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.out = (s_q.s3 & agree) | (s_q.out & ~agree);
    if (!nrst)
    begin
      s_d = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign dout = s_q.out;

endmodule

// >>> logic/ttc_thermal_throttle.sv
// Thermal throttle control: trip handling, clock modulation, hot and overheat pins, APB registers.
// Assumes comparator levels from the thermal sensor arrive asynchronously on pins.
module ttc_thermal_throttle
#(
  parameter logic [7:0] DIODE_OFFSET = 8'h00 // Factory diode correction, arbitrary default.
)
(
  input  wire logic        mclk,                 // Core clock, 25 MHz.
  input  wire logic        nrst,                 // Synchronous reset, active low.
  input  wire logic        psel,                 // APB select.
  input  wire logic        penable,              // APB enable.
  input  wire logic        pwrite,               // APB write.
  input  wire logic [11:0] paddr,                // APB byte address.
  input  wire logic [31:0] pwdata,               // APB write data.
  output logic      [31:0] prdata,               // APB read data.
  output logic             pready,               // APB ready.
  output logic             pslverr,              // APB error on unmapped address.
  input  wire logic        tempAtMax,            // Sensor at or above maximum, async.
  input  wire logic        tempBelowHyst,        // Sensor below hysteresis level, async.
  input  wire logic        tempCritical,         // Sensor at catastrophic level, async.
  input  wire logic        lowPower,             // Package in a low-power state, async.
  input  wire logic        irqReq,               // Incoming interrupt request pulse.
  output logic             irqService,           // Latched interrupt delivered, pulse.
  output logic             snoopEn,              // Bus snooping enabled.
  output logic             coreClkEn,            // Core clock gate enable.
  output logic             perfStateReq,         // Request lowest performance state.
  output logic      [3:0]  perfStateTarget,      // Lowest programmed performance state.
  output logic             dieHotOutN,           // Hot pin level, active low.
  output logic             dieHotOe,             // Hot pin drive enable.
  output logic             hotIrq,               // Hot edge interrupt, pulse.
  output logic             overheatShutdownOutN  // Catastrophic trip, active low.
);

  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              onDemandEn;
    logic [2:0]        odDuty;
    logic              fixedEn;
    logic              perfEn;
    logic              forceComb;
    logic              irqRise;
    logic              irqFall;
    logic [3:0]        pstate;
    ttc_pkg::ttc_auto_t mode;
    logic [11:0]       settle;
    logic              trip;
    logic              hot;
    logic              hotN;
    logic              hotOe;
    logic              hotLog;
    logic              hotIrq;
    logic              overheatN;
    logic [31:0]       gatedCnt;
    logic              irqLatch;
    logic              irqSvc;
    logic              perfReq;
    logic              modRun;
    logic [2:0]        modDuty;
    logic              clkEn;
    logic              snoop;
  } ttc_state_t;

  ttc_state_t s_q;
  ttc_state_t s_d;

  logic [ttc_pkg::SYNC_W-1:0] pins;
  logic                       atMax;
  logic                       belowHyst;
  logic                       critical;
  logic                       inLowPower;
  logic                       modClkOn;
  logic                       autoOn;
  logic                       setup;
  logic                       commit;
  logic                       mapped;
  logic [31:0]                rdata;

  ttc_sync3 u_sync
  (
    .mclk (mclk),
    .nrst (nrst),
    .din  ({lowPower, tempCritical, tempBelowHyst, tempAtMax}),
    .dout (pins)
  );

  assign atMax = pins[0];
  assign belowHyst = pins[1];
  assign critical = pins[2];
  assign inLowPower = pins[3];

  ttc_duty_mod u_mod
  (
    .mclk  (mclk),
    .nrst  (nrst),
    .run   (s_q.modRun),
    .duty  (s_q.modDuty),
    .clkOn (modClkOn)
  );

  always_comb
  begin
    s_d = s_q;
    autoOn = s_q.fixedEn | s_q.perfEn;
    setup = psel & penable & ~s_q.pready;
    commit = psel & penable & s_q.pready;
    mapped = (paddr == ttc_pkg::ADDR_ONDEMAND) || (paddr == ttc_pkg::ADDR_AUTO) ||
             (paddr == ttc_pkg::ADDR_STATUS) || (paddr == ttc_pkg::ADDR_COUNT) ||
             (paddr == ttc_pkg::ADDR_DIODE);

    // Read data is prepared one cycle ahead so that it stands with pready.
    rdata = '0;
    if (paddr == ttc_pkg::ADDR_ONDEMAND)
    begin
      rdata[ttc_pkg::OD_EN_BIT] = s_q.onDemandEn;
      rdata[ttc_pkg::OD_DUTY_MSB:ttc_pkg::OD_DUTY_LSB] = s_q.odDuty;
    end
    else if (paddr == ttc_pkg::ADDR_AUTO)
    begin
      rdata[ttc_pkg::AUTO_FIXED_BIT] = s_q.fixedEn;
      rdata[ttc_pkg::AUTO_PERF_BIT] = s_q.perfEn;
      rdata[ttc_pkg::AUTO_FORCE_BIT] = s_q.forceComb;
      rdata[ttc_pkg::IRQ_RISE_BIT] = s_q.irqRise;
      rdata[ttc_pkg::IRQ_FALL_BIT] = s_q.irqFall;
      rdata[ttc_pkg::PSTATE_MSB:ttc_pkg::PSTATE_LSB] = s_q.pstate;
    end
    else if (paddr == ttc_pkg::ADDR_STATUS)
    begin
      rdata[ttc_pkg::ST_THROTTLE] = s_q.modRun | s_q.perfReq;
      rdata[ttc_pkg::ST_HOT] = s_q.hot;
      rdata[ttc_pkg::ST_OVERHEAT] = ~s_q.overheatN;
      rdata[ttc_pkg::ST_HOTLOG] = s_q.hotLog;
      rdata[ttc_pkg::ST_PSTATE] = s_q.perfReq;
      rdata[ttc_pkg::ST_MOD] = s_q.modRun;
    end
    else if (paddr == ttc_pkg::ADDR_COUNT)
    begin
      rdata = s_q.gatedCnt;
    end
    else if (paddr == ttc_pkg::ADDR_DIODE)
    begin
      rdata[ttc_pkg::DIODE_OFS_LSB +: 8] = DIODE_OFFSET;
      rdata[ttc_pkg::IDEAL_LSB +: 8] = ttc_pkg::IDEALITY_HUNDREDTHS;
    end

    s_d.pready = setup;
    s_d.pslverr = setup & ~mapped;
    s_d.prdata = (setup & ~pwrite) ? rdata : '0;

    // Writes take effect at the edge where pready is seen high.
    if (commit && pwrite)
    begin
      if (paddr == ttc_pkg::ADDR_ONDEMAND)
      begin
        s_d.onDemandEn = pwdata[ttc_pkg::OD_EN_BIT];
        s_d.odDuty = pwdata[ttc_pkg::OD_DUTY_MSB:ttc_pkg::OD_DUTY_LSB];
      end
      else if (paddr == ttc_pkg::ADDR_AUTO)
      begin
        s_d.fixedEn = pwdata[ttc_pkg::AUTO_FIXED_BIT];
        s_d.perfEn = pwdata[ttc_pkg::AUTO_PERF_BIT];
        s_d.forceComb = pwdata[ttc_pkg::AUTO_FORCE_BIT];
        s_d.irqRise = pwdata[ttc_pkg::IRQ_RISE_BIT];
        s_d.irqFall = pwdata[ttc_pkg::IRQ_FALL_BIT];
        s_d.pstate = pwdata[ttc_pkg::PSTATE_MSB:ttc_pkg::PSTATE_LSB];
      end
      else if (paddr == ttc_pkg::ADDR_STATUS)
      begin
        if (pwdata[ttc_pkg::ST_HOTLOG])
        begin
          s_d.hotLog = 1'b0;
        end
      end
    end

    // The trip level has no register behind it; only the sensor comparators move it.
    if (atMax)
    begin
      s_d.trip = 1'b1;
    end
    else if (belowHyst)
    begin
      s_d.trip = 1'b0;
    end

    // In a low-power state the pin keeps whatever it shows until the state is left.
    if (inLowPower)
    begin
      s_d.hot = s_q.hot;
    end
    else
    begin
      s_d.hot = s_q.trip;
    end
    s_d.hotN = ~s_d.hot;
    s_d.hotOe = s_d.hot;
    s_d.hotIrq = (s_d.hot & ~s_q.hot & s_q.irqRise) | (~s_d.hot & s_q.hot & s_q.irqFall);
    if (s_d.hotIrq)
    begin
      s_d.hotLog = 1'b1;
    end

    // Automatic mode sequencing.
    s_d.settle = '0;
    unique case (s_q.mode)
      ttc_pkg::AUTO_RUN:
      begin
        if (s_q.trip && s_q.perfEn)
        begin
          s_d.mode = ttc_pkg::AUTO_PERF;
        end
        else if (s_q.trip && s_q.fixedEn)
        begin
          s_d.mode = ttc_pkg::AUTO_FIXED;
        end
      end
      ttc_pkg::AUTO_PERF:
      begin
        if (!s_q.trip || !s_q.perfEn)
        begin
          s_d.mode = ttc_pkg::AUTO_RUN;
        end
        else if (s_q.forceComb && (s_q.settle == ttc_pkg::SETTLE_LAST))
        begin
          s_d.mode = ttc_pkg::AUTO_COMBINED;
        end
        else
        begin
          s_d.settle = s_q.settle + 12'h001;
        end
      end
      ttc_pkg::AUTO_COMBINED:
      begin
        if (!s_q.trip || !s_q.perfEn || !s_q.forceComb)
        begin
          s_d.mode = ttc_pkg::AUTO_RUN;
        end
      end
      ttc_pkg::AUTO_FIXED:
      begin
        if (!s_q.trip || !autoOn)
        begin
          s_d.mode = ttc_pkg::AUTO_RUN;
        end
        else if (s_q.perfEn)
        begin
          s_d.mode = ttc_pkg::AUTO_PERF;
        end
      end
    endcase

    s_d.perfReq = (s_q.mode == ttc_pkg::AUTO_PERF) || (s_q.mode == ttc_pkg::AUTO_COMBINED);

    // Automatic modulation wins; on-demand only acts while no automatic response runs.
    if ((s_q.mode == ttc_pkg::AUTO_FIXED) || (s_q.mode == ttc_pkg::AUTO_COMBINED))
    begin
      s_d.modRun = 1'b1;
      s_d.modDuty = ttc_pkg::FIXED_DUTY;
    end
    else if (s_q.onDemandEn && (s_q.mode == ttc_pkg::AUTO_RUN))
    begin
      s_d.modRun = 1'b1;
      s_d.modDuty = (s_q.odDuty == ttc_pkg::DUTY_RESERVED) ? ttc_pkg::FIXED_DUTY : s_q.odDuty;
    end
    else
    begin
      s_d.modRun = 1'b0;
      s_d.modDuty = ttc_pkg::FIXED_DUTY;
    end

    // The overheat trip is sticky and acts without any bus involvement.
    if (critical)
    begin
      s_d.overheatN = 1'b0;
    end
    s_d.clkEn = modClkOn & s_d.overheatN;
    if (!s_q.clkEn)
    begin
      s_d.gatedCnt = s_q.gatedCnt + 32'h0000_0001;
    end

    // A request arriving while a latched one is delivered stays latched.
    s_d.irqSvc = s_q.irqLatch & s_q.clkEn;
    s_d.irqLatch = irqReq | (s_q.irqLatch & ~s_q.clkEn);
    s_d.snoop = 1'b1;

    if (!nrst)
    begin
      s_d = '0;
      s_d.mode = ttc_pkg::AUTO_RUN;
      s_d.fixedEn = 1'b1;
      s_d.perfEn = 1'b1;
      s_d.hotN = 1'b1;
      s_d.overheatN = 1'b1;
      s_d.clkEn = 1'b1;
      s_d.snoop = 1'b1;
      s_d.modDuty = ttc_pkg::FIXED_DUTY;
    end
  end

  always_ff @(posedge mclk)
  begin
    s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irqService = s_q.irqSvc;
  assign snoopEn = s_q.snoop;
  assign coreClkEn = s_q.clkEn;
  assign perfStateReq = s_q.perfReq;
  assign perfStateTarget = s_q.pstate;
  assign dieHotOutN = s_q.hotN;
  assign dieHotOe = s_q.hotOe;
  assign hotIrq = s_q.hotIrq;
  assign overheatShutdownOutN = s_q.overheatN;

endmodule

// >>> verification/thermal_throttle_control_tb_top.sv
// Self-checking bench for the thermal throttle block with a platform model.
// Assumes the checker is bound from its own file and the package is compiled first.
module thermal_throttle_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lowPower = 1'b0, irqReq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, tempAtMax, tempBelowHyst, tempCritical, irqService, snoopEn;
  logic coreClkEn, perfStateReq, dieHotOutN, dieHotOe, hotIrq, overheatShutdownOutN;
  logic coreSupplyOn, e;
  logic [3:0] perfStateTarget;
  int dieTemp = 40, mismatches = 0, cmp_count = 0, hotSeen = 0, n, p;

  ttc_thermal_throttle #(.DIODE_OFFSET(8'h3c)) ttc_thermal_throttle_inst
  (
    .mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tempAtMax, .tempBelowHyst, .tempCritical, .lowPower, .irqReq, .irqService, .snoopEn,
    .coreClkEn, .perfStateReq, .perfStateTarget, .dieHotOutN, .dieHotOe, .hotIrq,
    .overheatShutdownOutN
  );
  ttc_platform_model ttc_platform_model_inst
  (
    .mclk, .nrst, .dieTemp, .overheatShutdownOutN, .tempAtMax, .tempBelowHyst,
    .tempCritical, .coreSupplyOn
  );

  always #20 mclk = ~mclk;
  always @(posedge mclk) if (hotIrq === 1'b1) hotSeen++;

  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Each transfer waits for ready; the read data and error are taken at that edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  // Counts clock-on cycles over one full modulation period after a settling span.
  task automatic on_cnt(input int settle, output int c);
    c = 0;
    repeat (settle) @(posedge mclk);
    repeat (128) @(posedge mclk) c += int'(coreClkEn === 1'b1);
  endtask

  // Mode 0 none, 1 fixed duty, 2 performance state, 3 performance state plus modulation.
  function automatic int model_on(int hot, int mode, int odEn, int duty);
    if (hot != 0 && mode == 2)
      return 128;
    if (hot != 0 && mode != 0)
      return 64;
    if (odEn != 0)
      return (duty == 0) ? 64 : duty * 16;
    return 128;
  endfunction

  initial
  begin
    p = $urandom(32'hc365);
    p = $urandom_range(15, 1);
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, ttc_pkg::ADDR_DIODE, 32'h0, r, e);
    chk(r, (32'd101 << 16) | 32'h3c);
    wr(ttc_pkg::ADDR_DIODE, 32'hffffffff);
    apb(1'b0, ttc_pkg::ADDR_DIODE, 32'h0, r, e);
    chk(r, (32'd101 << 16) | 32'h3c);
    apb(1'b0, ttc_pkg::ADDR_AUTO, 32'h0, r, e);
    chk(r, 32'h3);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(e, 1'b1);
    for (int k = 0; k < 8; k++)
    begin
      wr(ttc_pkg::ADDR_ONDEMAND, 32'(16 + 2 * k));
      on_cnt(140, n);
      chk(n, model_on(0, 1, 1, k));
    end
    wr(ttc_pkg::ADDR_ONDEMAND, 32'h0);
    on_cnt(140, n);
    chk(n, model_on(0, 1, 0, 0));
    wr(ttc_pkg::ADDR_AUTO, 32'h31);
    wr(ttc_pkg::ADDR_ONDEMAND, 32'h12);
    dieTemp <= 110;
    on_cnt(140, n);
    chk(n, model_on(1, 1, 1, 1));
    chk(dieHotOutN, 1'b0);
    irqReq <= 1'b1;
    @(posedge mclk) irqReq <= 1'b0;
    apb(1'b0, ttc_pkg::ADDR_STATUS, 32'h0, r, e);
    chk(r[5:0], 6'h2b);
    wr(ttc_pkg::ADDR_STATUS, 32'h8);
    apb(1'b0, ttc_pkg::ADDR_STATUS, 32'h0, r, e);
    chk(r[3], 1'b0);
    dieTemp <= 98;
    on_cnt(140, n);
    chk(n, model_on(1, 1, 1, 1));
    dieTemp <= 90;
    on_cnt(140, n);
    chk(n, model_on(0, 1, 1, 1));
    chk(hotSeen, 2);
    wr(ttc_pkg::ADDR_ONDEMAND, 32'h0);
    wr(ttc_pkg::ADDR_AUTO, 32'(p << 8) | 32'h3);
    dieTemp <= 110;
    on_cnt(140, n);
    chk(n, model_on(1, 2, 0, 0));
    chk(perfStateReq, 1'b1);
    chk(perfStateTarget, p);
    dieTemp <= 90;
    on_cnt(140, n);
    chk(perfStateReq, 1'b0);
    wr(ttc_pkg::ADDR_AUTO, 32'(p << 8) | 32'h7);
    dieTemp <= 110;
    on_cnt(1000, n);
    chk(n, model_on(1, 2, 0, 0));
    on_cnt(1500, n);
    chk(n, model_on(1, 3, 0, 0));
    dieTemp <= 90;
    repeat (40) @(posedge mclk);
    lowPower <= 1'b1;
    repeat (10) @(posedge mclk);
    dieTemp <= 110;
    repeat (40) @(posedge mclk);
    chk(dieHotOutN, 1'b1);
    lowPower <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(dieHotOutN, 1'b0);
    lowPower <= 1'b1;
    repeat (10) @(posedge mclk);
    dieTemp <= 90;
    repeat (40) @(posedge mclk);
    chk(dieHotOutN, 1'b0);
    lowPower <= 1'b0;
    repeat (40) @(posedge mclk);
    chk(dieHotOutN, 1'b1);
    dieTemp <= 130;
    repeat (30) @(posedge mclk);
    chk({overheatShutdownOutN, coreClkEn, coreSupplyOn}, 3'b000);
    dieTemp <= 90;
    repeat (30) @(posedge mclk);
    chk(overheatShutdownOutN, 1'b0);
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({overheatShutdownOutN, coreClkEn}, 2'b11);
    apb(1'b0, ttc_pkg::ADDR_COUNT, 32'h0, r, e);
    chk(r, 32'h0);
    test_done;
  end

  initial
  begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    $display("wrong value at %0t: run timed out", $time);
    test_done;
  end
endmodule

// >>> verification/ttc_platform_model.sv
// Platform model: turns a die temperature into sensor levels and cuts the core supply.
// Assumes the bench sets dieTemp in degrees right after a clock edge.
module ttc_platform_model
#(
  parameter int TRIP_C  = 100, // Maximum operating temperature.
  parameter int HYST_C  = 97,  // Release point below the trip.
  parameter int CRIT_C  = 125, // Catastrophic temperature.
  parameter int CUT_CYC = 10   // Cycles allowed to remove the supply.
)
(
  input  wire logic mclk,                 // Core clock.
  input  wire logic nrst,                 // Reset, active low.
  input  int        dieTemp,              // Die temperature in degrees.
  input  wire logic overheatShutdownOutN, // Overheat trip from the device.
  output logic      tempAtMax = 1'b0,     // At or above the trip.
  output logic      tempBelowHyst = 1'b1, // Below the release point.
  output logic      tempCritical = 1'b0,  // Catastrophic level.
  output logic      coreSupplyOn = 1'b1   // Core supply present.
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;

  always @(posedge mclk)
  begin
    tempAtMax <= dieTemp >= TRIP_C;
    tempBelowHyst <= dieTemp < HYST_C;
    tempCritical <= dieTemp >= CRIT_C;
    cnt <= overheatShutdownOutN ? 0 : cnt + 1;
    if (!nrst)
      coreSupplyOn <= 1'b1;
    else if (cnt == CUT_CYC)
      coreSupplyOn <= 1'b0;
  end
endmodule

// >>> verification/ttc_thermal_throttle_chk.sv
// Checker for the thermal throttle block: APB timing, hot pin and overheat trip.
// Assumes it is bound to ttc_thermal_throttle and sees only its ports.
module ttc_thermal_throttle_chk
(
  input wire logic        mclk,                // Core clock.
  input wire logic        nrst,                // Reset, active low.
  input wire logic        psel,                // APB select.
  input wire logic        penable,             // APB enable.
  input wire logic        pwrite,              // APB write.
  input wire logic [31:0] prdata,              // APB read data.
  input wire logic        pready,              // APB ready.
  input wire logic        pslverr,             // APB error.
  input wire logic        tempCritical,        // Critical level.
  input wire logic        lowPower,            // Low-power state.
  input wire logic        irqReq,              // Interrupt request.
  input wire logic        irqService,          // Interrupt delivered.
  input wire logic        snoopEn,             // Snooping enabled.
  input wire logic        coreClkEn,           // Core clock gate.
  input wire logic        dieHotOutN,          // Hot pin.
  input wire logic        dieHotOe,            // Hot pin drive.
  input wire logic        hotIrq,              // Hot edge pulse.
  input wire logic        overheatShutdownOutN // Overheat trip.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not after one wait state");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  hot_drive_a: assert property (dieHotOe == !dieHotOutN)
    else $error("hot pin drive disagrees with level");
  irq_service_a: assert property (irqReq |-> ##[1:130] irqService)
    else $error("latched interrupt never serviced");
  snoop_on_a: assert property (snoopEn)
    else $error("snooping stopped");
  hot_pulse_a: assert property (hotIrq |=> !hotIrq)
    else $error("hot interrupt longer than one cycle");
  trip_crit_a: assert property (tempCritical [*8] |-> !overheatShutdownOutN)
    else $error("no overheat trip at critical level");
  trip_hold_a: assert property (!overheatShutdownOutN |=> !overheatShutdownOutN)
    else $error("overheat trip released");
  trip_gate_a: assert property (!overheatShutdownOutN [*3] |-> !coreClkEn)
    else $error("core clocks run after overheat trip");
  lp_freeze_a: assert property (lowPower [*6] |-> $stable(dieHotOutN))
    else $error("hot pin moved in low-power state");
endmodule

bind ttc_thermal_throttle ttc_thermal_throttle_chk ttc_thermal_throttle_chk_inst
(
  .mclk, .nrst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .tempCritical,
  .lowPower, .irqReq, .irqService, .snoopEn, .coreClkEn, .dieHotOutN, .dieHotOe,
  .hotIrq, .overheatShutdownOutN
);
